// ### scl_pkg.sv
// Purpose: constants and carriers for the serial-controller special lines
// Assumes: one clock, synchronous active-high reset
// Notes: register indices follow the serial controller's own numbering
// Overview of operation
// - loop-back disables every frontplane receiver
// - ctrl0 A reg5 bit7 set asserts loop_n
// - loop-back deasserted after reset
// - sense high without hood, else lamp complement
// - ctrl0 reg0 bit5 reads sense, 1=grounded
// - reset sense low with hood, high without
// - ctrl0 A ready drives request two low
// - ctrl0 B ready drives request zero low
// - ready requests float after reset
// - ctrl1 B reg5 bit7 set lights lamp
// - hood lamp off after reset
// - no other modem lines used
// - loop-back feeds each transmit to receive
// - one loop control for all eight channels
package scl_pkg;
	// address: [4]=controller, [3]=channel B, [2:0]=register number
	localparam logic [4:0] ADDR_C0A_WR5 = 5'h05;
	localparam logic [4:0] ADDR_C0A_RR0 = 5'h00;
	localparam logic [4:0] ADDR_C0B_WR5 = 5'h0D;
	localparam logic [4:0] ADDR_C1B_WR5 = 5'h1D;
	// own choice: ready-mode control register per channel (register 1)
	localparam logic [4:0] ADDR_C0A_WR1 = 5'h01;
	localparam logic [4:0] ADDR_C0B_WR1 = 5'h09;
	localparam int BIT_LOOP = 7;
	localparam int BIT_LAMP = 7;
	localparam int BIT_SENSE = 5;
	localparam int BIT_RDY_EN = 6;
	localparam logic RST_LOOP = 1'b0;
	localparam logic RST_LAMP = 1'b0;
	localparam logic RST_RDY_EN = 1'b0;
	localparam logic RST_RDY_LVL = 1'b0; // ready level held after reset
	localparam logic [7:0] RST_RDATA = 8'h00; // read answer after reset
	localparam int NUM_CHAN = 8;
	// register bus request
	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} scl_bus_t;
	// per-channel line pair
	typedef struct packed {
		logic txd;
		logic rxd;
	} scl_line_t;
endpackage : scl_pkg

// ### scl_chan_path.sv
// Purpose: one channel's receive path with loop-back selection
// Assumes: loop and line levels synchronous to clk_sys
// Notes: receiver isolated while loop-back is on
module scl_chan_path (
	// control
	input wire logic loopOn,
	// line side
	input wire logic extRxd,
	input wire logic txd,
	// controller side
	output logic rxd,
	output logic rcvEn
);
	// transmit wraps straight to receive while looping
	assign rxd = loopOn ? txd : extRxd;
	// receiver enable drops so outside data cannot leak in
	assign rcvEn = ~loopOn;
endmodule : scl_chan_path

// ### scl_special_lines.sv
// Purpose: special control and sense lines of the serial controllers
// Assumes: plain register port, read data one cycle after read strobe
// Notes: ready outputs are three-state; enable high drives the pin
//
// The placing of the registers and strobed register access were decided locally.
module scl_special_lines (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clkEn,
	// register port
	input wire scl_pkg::scl_bus_t bus,
	output logic [7:0] rdData,
	// channel lines
	input wire logic [scl_pkg::NUM_CHAN-1:0] chanTxd,
	input wire logic [scl_pkg::NUM_CHAN-1:0] lineRxd,
	output logic [scl_pkg::NUM_CHAN-1:0] chanRxd,
	output logic [scl_pkg::NUM_CHAN-1:0] rcvEn,
	// special lines
	output logic loop_n,
	output logic hood_lamp_n,
	input wire logic hoodSense_n,
	// ready handshakes from the controllers' channel logic
	input wire logic readyA,
	input wire logic readyB,
	output logic dma_ready_req_a_n,
	output logic dma_ready_req_a_oe,
	output logic dma_ready_req_b_n,
	output logic dma_ready_req_b_oe
);
	import scl_pkg::*;

	// the block sits between the card processor's register port and a few
	// spare modem pins of the serial controllers; every control bit lives
	// here as one flip-flop so the pins never glitch on a partial write
	// limitation: registers other than the mapped ones are not modelled,
	// so a write to them is silently dropped and a read returns zero
	// trade-off: ready pins are registered, which costs one cycle of
	// latency on the request line but keeps them free of input hazards
	// clock enable low freezes every flip-flop; reset still wins

	logic loop_q; // loop-back control bit
	logic lamp_q; // hood lamp control bit
	logic rdyEnA_q; // channel A ready mode
	logic rdyEnB_q; // channel B ready mode
	logic [7:0] rdData_q; // read answer
	logic ctrl_ready_out_a_n_q; // registered ready levels
	logic ctrl_ready_out_b_n_q;
	logic wrHit;

	// a write counts only on an enabled edge; reads gate on clkEn below
	// hazard: without this gate a frozen block would still take writes
	assign wrHit = clkEn && bus.wr;

	// loop-back bit; reset leaves it off
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			loop_q <= RST_LOOP;
		end else if (wrHit && bus.addr == ADDR_C0A_WR5) begin
			loop_q <= bus.wdata[BIT_LOOP];
		end
	end

	// hood lamp bit; reset leaves lamp dark
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lamp_q <= RST_LAMP;
		end else if (wrHit && bus.addr == ADDR_C1B_WR5) begin
			lamp_q <= bus.wdata[BIT_LAMP];
		end
	end

	// ready-mode enables; floating until programmed
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdyEnA_q <= RST_RDY_EN;
			rdyEnB_q <= RST_RDY_EN;
		end else if (wrHit) begin
			if (bus.addr == ADDR_C0A_WR1) begin
				rdyEnA_q <= bus.wdata[BIT_RDY_EN];
			end else if (bus.addr == ADDR_C0B_WR1) begin
				rdyEnB_q <= bus.wdata[BIT_RDY_EN];
			end
		end
	end

	// ready levels registered so the pins come from flip-flops
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_ready_out_a_n_q <= RST_RDY_LVL;
			ctrl_ready_out_b_n_q <= RST_RDY_LVL;
		end else if (clkEn) begin
			ctrl_ready_out_a_n_q <= readyA;
			ctrl_ready_out_b_n_q <= readyB;
		end
	end

	// read port; only the sense bit is mapped, the rest reads zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdData_q <= RST_RDATA;
		end else if (clkEn) begin
			rdData_q <= 8'h00;
			if (bus.rd && bus.addr == ADDR_C0A_RR0) begin
				// grounded line reads 1, pulled-up reads 0
				rdData_q[BIT_SENSE] <= ~hoodSense_n;
			end
		end
	end

	assign rdData = rdData_q;
	// active-low outputs straight from control bits
	assign loop_n = ~loop_q;
	assign hood_lamp_n = ~lamp_q;
	// request pins pulled low while channel ready, released otherwise
	assign dma_ready_req_a_n = ~ctrl_ready_out_a_n_q;
	assign dma_ready_req_a_oe = rdyEnA_q;
	assign dma_ready_req_b_n = ~ctrl_ready_out_b_n_q;
	assign dma_ready_req_b_oe = rdyEnB_q;
	// no other modem pins exist on this block

	// one loop bit fans out to all channels
	// limitation: no channel can be looped alone; the single control bit
	// is shared on purpose so a self-test always isolates the whole card
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHAN; gi++) begin : gChan
			scl_chan_path uPath (
				.loopOn(loop_q),
				.extRxd(lineRxd[gi]),
				.txd(chanTxd[gi]),
				.rxd(chanRxd[gi]),
				.rcvEn(rcvEn[gi])
			);
		end
	endgenerate

	// checks
	sequence lampWrite_s;
		clkEn && bus.wr && bus.addr == ADDR_C1B_WR5 && bus.wdata[BIT_LAMP];
	endsequence

	loop_write_a: assert property (@(posedge clk_sys) disable iff (srst)
		clkEn && bus.wr && bus.addr == ADDR_C0A_WR5 |=> loop_n == ~$past(bus.wdata[BIT_LOOP]))
		else $error("loop output does not follow write");
	loop_reset_a: assert property (@(posedge clk_sys)
		srst |=> loop_n)
		else $error("loop asserted after reset");
	rcv_iso_a: assert property (@(posedge clk_sys) disable iff (srst)
		!loop_n |-> rcvEn == '0)
		else $error("receiver enabled during loop");
	loop_path_a: assert property (@(posedge clk_sys) disable iff (srst)
		!loop_n |-> chanRxd == chanTxd)
		else $error("transmit not looped to receive");
	sense_read_a: assert property (@(posedge clk_sys) disable iff (srst)
		clkEn && bus.rd && bus.addr == ADDR_C0A_RR0 |=> rdData[BIT_SENSE] == !$past(hoodSense_n))
		else $error("sense bit wrong");
	lamp_write_a: assert property (@(posedge clk_sys) disable iff (srst)
		lampWrite_s |=> !hood_lamp_n)
		else $error("lamp not lit after write");
	lamp_reset_a: assert property (@(posedge clk_sys)
		srst |=> hood_lamp_n ##0 !dma_ready_req_a_oe && !dma_ready_req_b_oe)
		else $error("lamp or request driven after reset");
	req_float_a: assert property (@(posedge clk_sys)
		$fell(srst) |-> !dma_ready_req_a_oe && !dma_ready_req_b_oe)
		else $error("request driven before programming");
	req_a_a: assert property (@(posedge clk_sys) disable iff (srst)
		clkEn && readyA && dma_ready_req_a_oe ##1 dma_ready_req_a_oe |-> !dma_ready_req_a_n)
		else $error("request two not low when ready");
	req_b_a: assert property (@(posedge clk_sys) disable iff (srst)
		clkEn && readyB && dma_ready_req_b_oe ##1 dma_ready_req_b_oe |-> !dma_ready_req_b_n)
		else $error("request zero not low when ready");

	// mask of the only mapped bit in the status byte
	localparam logic [7:0] SENSE_MASK = 8'h01 << BIT_SENSE;

	// one sequence per kind of register access, reused below
	sequence loopWrite_s;
		clkEn && bus.wr && bus.addr == ADDR_C0A_WR5;
	endsequence
	sequence lampAny_s;
		clkEn && bus.wr && bus.addr == ADDR_C1B_WR5;
	endsequence
	sequence senseRead_s;
		clkEn && bus.rd && bus.addr == ADDR_C0A_RR0;
	endsequence
	sequence modeWriteA_s;
		clkEn && bus.wr && bus.addr == ADDR_C0A_WR1;
	endsequence
	sequence modeWriteB_s;
		clkEn && bus.wr && bus.addr == ADDR_C0B_WR1;
	endsequence
	sequence frozen_s;
		!clkEn;
	endsequence

	// loop control: set, clear and hold
	loop_set_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		loopWrite_s ##0 bus.wdata[BIT_LOOP] |=> !loop_n)
		else $error("loop not asserted by a written one");
	loop_clr_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		loopWrite_s ##0 !bus.wdata[BIT_LOOP] |=> loop_n)
		else $error("loop not released by a written zero");
	loop_hold_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		!(clkEn && bus.wr && bus.addr == ADDR_C0A_WR5)
		|=> $stable(loop_n))
		else $error("loop output moved without a write");

	// lamp control: clear and hold; the set is checked above
	lamp_clr_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		lampAny_s ##0 !bus.wdata[BIT_LAMP] |=> hood_lamp_n)
		else $error("lamp not dark after a written zero");
	lamp_hold_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		!(clkEn && bus.wr && bus.addr == ADDR_C1B_WR5)
		|=> $stable(hood_lamp_n))
		else $error("lamp output moved without a write");

	// channel paths outside loop-back, and all channels together
	rcv_open_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		loop_n |-> rcvEn == '1)
		else $error("receiver disabled without loop");
	line_path_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		loop_n |-> chanRxd == lineRxd)
		else $error("line data not passed to receive");
	loop_all_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		rcvEn == {NUM_CHAN{loop_n}})
		else $error("channels not switched together");

	// read port: only the sense bit, and only after a status read
	rd_mask_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		senseRead_s |=> (rdData & ~SENSE_MASK) == 8'h00)
		else $error("unmapped status bits not zero");
	rd_idle_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		clkEn && !(bus.rd && bus.addr == ADDR_C0A_RR0)
		|=> rdData == 8'h00)
		else $error("read data left standing");
	rd_reset_a: assert property (
		@(posedge clk_sys)
		srst |=> rdData == RST_RDATA)
		else $error("read data not cleared by reset");

	// ready mode bits decide whether the request pins are driven
	mode_a_on_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		modeWriteA_s ##0 bus.wdata[BIT_RDY_EN] |=> dma_ready_req_a_oe)
		else $error("request two not driven after mode write");
	mode_a_off_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		modeWriteA_s ##0 !bus.wdata[BIT_RDY_EN] |=> !dma_ready_req_a_oe)
		else $error("request two still driven after mode clear");
	mode_b_on_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		modeWriteB_s ##0 bus.wdata[BIT_RDY_EN] |=> dma_ready_req_b_oe)
		else $error("request zero not driven after mode write");
	mode_b_off_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		modeWriteB_s ##0 !bus.wdata[BIT_RDY_EN] |=> !dma_ready_req_b_oe)
		else $error("request zero still driven after mode clear");
	mode_hold_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		!(clkEn && bus.wr && (bus.addr == ADDR_C0A_WR1 ||
			bus.addr == ADDR_C0B_WR1)) |=> $stable(dma_ready_req_a_oe)
		&& $stable(dma_ready_req_b_oe))
		else $error("request enable moved without a write");

	// request levels follow ready one edge late; reset releases them
	req_a_idle_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		clkEn && !readyA |=> dma_ready_req_a_n)
		else $error("request two low without ready");
	req_b_idle_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		clkEn && !readyB |=> dma_ready_req_b_n)
		else $error("request zero low without ready");
	req_reset_a: assert property (
		@(posedge clk_sys)
		srst |=> dma_ready_req_a_n && dma_ready_req_b_n)
		else $error("request level not idle after reset");

	// clock enable low must freeze every output that comes from state
	freeze_ctl_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		frozen_s |=> $stable(loop_n) && $stable(hood_lamp_n))
		else $error("control output moved while frozen");
	freeze_oe_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		frozen_s |=> $stable(dma_ready_req_a_oe)
		&& $stable(dma_ready_req_b_oe))
		else $error("request enable moved while frozen");
	freeze_req_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		frozen_s |=> $stable(dma_ready_req_a_n)
		&& $stable(dma_ready_req_b_n))
		else $error("request level moved while frozen");
	freeze_rd_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		frozen_s |=> $stable(rdData))
		else $error("read data moved while frozen");
endmodule : scl_special_lines

// ### scl_hood_model.sv
// Purpose: diagnostic hood and memory interface request pins
// Assumes: bench sets whether the hood is fitted
// Notes: a floating request pin reads high through its pull-up
module scl_hood_model (
	// hood
	input wire logic fitted,
	input wire logic lamp_n,
	output logic sense_n,
	// request pins
	input wire logic reqA_n,
	input wire logic reqAOe,
	input wire logic reqB_n,
	input wire logic reqBOe,
	output logic reqTwo_n,
	output logic reqZero_n
);
	// absent hood leaves the pull-up; fitted hood inverts the lamp
	assign sense_n = fitted ? ~lamp_n : 1'b1;
	// undriven pins must not look like a request
	assign reqTwo_n = reqAOe ? reqA_n : 1'b1;
	assign reqZero_n = reqBOe ? reqB_n : 1'b1;
endmodule : scl_hood_model

// ### scl_special_lines_tb_top.sv
// Purpose: bench for the serial-controller special lines
// Assumes: hood fitted at start, clock enable high but in one scenario
// Notes: fixed waits follow the one-cycle answers of the port
module scl_special_lines_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import scl_pkg::*;
	logic clk_sys = 0, srst = 1, fitted = 1, readyA = 0, readyB = 0;
	logic clkEn = 1; // freezes the block while low
	logic [7:0] txd = 8'hA5, rxl = 8'h5A, rd, rdData, chanRxd, rcvEn;
	logic loop_n, lamp_n, sense_n, aN, aOe, bN, bOe, two_n, zero_n;
	scl_bus_t bus = '0;
	int mismatches = 0, compares = 0;
	scl_special_lines u_dut (.clk_sys, .srst, .clkEn, .bus,
		.rdData, .chanTxd(txd), .lineRxd(rxl), .chanRxd, .rcvEn, .loop_n,
		.hood_lamp_n(lamp_n), .hoodSense_n(sense_n), .readyA, .readyB,
		.dma_ready_req_a_n(aN), .dma_ready_req_a_oe(aOe),
		.dma_ready_req_b_n(bN), .dma_ready_req_b_oe(bOe));
	scl_hood_model u_hood (.fitted, .lamp_n, .sense_n, .reqA_n(aN),
		.reqAOe(aOe), .reqB_n(bN), .reqBOe(bOe), .reqTwo_n(two_n),
		.reqZero_n(zero_n));
	// 100 ns period
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys) bus <= '0;
		#1;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rdReg(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk_sys) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys) bus <= '0;
		#1 d = rdData;
	endtask : rdReg
	task automatic tReset;
		#1 chk({4'h0, loop_n, lamp_n, aOe, bOe}, 8'h0C);
		rdReg(ADDR_C0A_RR0, rd);
		chk(rd & 8'h20, 8'h20);
		rdReg(ADDR_C0B_WR5, rd);
		chk(rd, 8'h00);
	endtask : tReset
	// with the enable low no write is taken
	task automatic tFreeze;
		@(posedge clk_sys) clkEn <= 1'b0;
		wr(ADDR_C0A_WR5, 8'h80);
		chk({7'h0, loop_n}, 8'h01);
		@(posedge clk_sys) clkEn <= 1'b1;
	endtask : tFreeze
	// all eight channels switch together
	task automatic tLoop;
		// line drivers sit outside this block; firmware has them off here
		wr(ADDR_C0A_WR5, 8'h80);
		chk({7'h0, loop_n}, 8'h00);
		chk(rcvEn, 8'h00);
		chk(chanRxd, txd);
		wr(ADDR_C0A_WR5, 8'h00);
		chk(rcvEn, 8'hFF);
		chk(chanRxd, rxl);
	endtask : tLoop
	// lamp pattern read back through the sense bit, hood then removed
	task automatic tLamp;
		logic on;
		for (int i = 0; i < 4; i++) begin
			on = i[0];
			fitted = (i < 2);
			wr(ADDR_C1B_WR5, {on, 7'h00});
			chk({7'h0, lamp_n}, {7'h0, !on});
			rdReg(ADDR_C0A_RR0, rd);
			chk(rd & 8'h20, {2'h0, fitted && !on, 5'h0});
		end
	endtask : tLamp
	task automatic tReady;
		wr(ADDR_C0A_WR1, 8'h40);
		wr(ADDR_C0B_WR1, 8'h40);
		@(posedge clk_sys) readyA <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 chk({4'h0, aOe, bOe, two_n, zero_n}, 8'h0D);
		@(posedge clk_sys) readyA <= 1'b0;
		readyB <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 chk({6'h0, two_n, zero_n}, 8'h02);
	endtask : tReady
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	// watchdog against a hung sequence
	initial begin
		repeat (3000) @(posedge clk_sys);
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		tReset();
		tFreeze();
		tLoop();
		tLamp();
		tReady();
		wrap_up();
	end
endmodule : scl_special_lines_tb_top
